// ### cag_addr_gen.sv
module cag_addr_gen (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                instr_valid_i,
  input  wire cag_pkg::cag_op_t    op_i,
  input  wire cag_pkg::cag_alu_t   alu_op_i,
  input  wire logic [4:0]          dest_reg_i,
  input  wire logic [4:0]          src_reg_i,
  input  wire logic [5:0]          io_addr_i,
  input  wire cag_pkg::cag_ptr_t   ptr_sel_i,
  input  wire cag_pkg::cag_pmode_t ptr_mode_i,
  input  wire logic [5:0]          disp_i,
  input  wire logic [15:0]         data_word_i,
  input  wire logic [11:0]         rel_off_i,
  input  wire logic [7:0]          io_rdata_i,
  input  wire logic [7:0]          sram_rdata_i,
  input  wire logic [15:0]         pmem_rdata_i,
  output logic                     ready_o,
  output logic      [13:0]         pc_o,
  output logic                     flush_o,
  output logic                     call_o,
  output logic      [13:0]         ret_addr_o,
  output logic                     io_req_o,
  output logic                     io_we_o,
  output logic      [5:0]          io_addr_o,
  output logic      [7:0]          io_wdata_o,
  output logic                     sram_req_o,
  output logic                     sram_we_o,
  output logic      [15:0]         sram_addr_o,
  output logic      [7:0]          sram_wdata_o,
  output logic                     pmem_rd_o,
  output logic                     pmem_wr_o,
  output logic      [13:0]         pmem_addr_o,
  output logic      [15:0]         pmem_wdata_o
);
  cag_pkg::cag_state_t state;
  logic        accept;
  logic [7:0]  rd_a;
  logic [7:0]  rd_b;
  logic [7:0]  rd_c;
  logic [15:0] ptr_a;
  logic [15:0] ptr_b;
  logic [15:0] ptr_c;
  logic [15:0] pair0;
  logic [15:0] ptr_val;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] eff_ind;
  logic [15:0] eff_addr;
  logic [15:0] io_off;
  logic        is_ld;
  logic        is_st;
  logic        is_mem;
  logic        in_regs;
  logic        in_io;
  logic        in_sram;
  logic        ptr_wb;
  logic [7:0]  alu_res;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [4:0]  pend_reg;
  logic        pend_hi;
  logic [7:0]  pm_byte;
  logic [13:0] pc_inc1;
  logic [13:0] rel_tgt;
  logic [13:0] next_pc;
  logic        is_jump;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  cag_regfile u_regfile (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .wr_en_i      (wr_en),
    .wr_addr_i    (wr_addr),
    .wr_data_i    (wr_data),
    .pair_wr_en_i (ptr_wb),
    .pair_sel_i   (ptr_sel_i),
    .pair_data_i  (ptr_mode_i == cag_pkg::CAG_PM_PREDEC ? ptr_dec : ptr_inc),
    .rd_a_addr_i  (dest_reg_i),
    .rd_b_addr_i  (src_reg_i),
    .rd_c_addr_i  (eff_addr[4:0]),
    .rd_a_data_o  (rd_a),
    .rd_b_data_o  (rd_b),
    .rd_c_data_o  (rd_c),
    .ptr_a_o      (ptr_a),
    .ptr_b_o      (ptr_b),
    .ptr_c_o      (ptr_c),
    .pair0_o      (pair0)
  );

  // ----------------------------------------------------------------
  // Operand address
  // ----------------------------------------------------------------
  assign ready_o = (state == cag_pkg::CAG_ST_EXEC);
  assign accept  = instr_valid_i && ready_o;

  always_comb begin
    unique case (ptr_sel_i)
      cag_pkg::CAG_PTR_A: ptr_val = ptr_a;
      cag_pkg::CAG_PTR_B: ptr_val = ptr_b;
      cag_pkg::CAG_PTR_C: ptr_val = ptr_c;
      default:            ptr_val = ptr_c;
    endcase
  end

  assign ptr_dec = ptr_val - cag_pkg::PTR_STEP;
  assign ptr_inc = ptr_val + cag_pkg::PTR_STEP;

  // Displacement on pointer_a is not an encodable form; it falls to plain
  always_comb begin
    unique case (ptr_mode_i)
      cag_pkg::CAG_PM_PLAIN:   eff_ind = ptr_val;
      cag_pkg::CAG_PM_PREDEC:  eff_ind = ptr_dec;
      cag_pkg::CAG_PM_POSTINC: eff_ind = ptr_val;
      cag_pkg::CAG_PM_DISP:    eff_ind = (ptr_sel_i == cag_pkg::CAG_PTR_A)
                                         ? ptr_val
                                         : ptr_val + {10'h000, disp_i};
      default:                 eff_ind = ptr_val;
    endcase
  end

  assign is_ld    = (op_i == cag_pkg::CAG_OP_LD) ||
                    (op_i == cag_pkg::CAG_OP_LDS);
  assign is_st    = (op_i == cag_pkg::CAG_OP_ST) ||
                    (op_i == cag_pkg::CAG_OP_STS);
  assign is_mem   = is_ld || is_st;
  assign eff_addr = (op_i == cag_pkg::CAG_OP_LDS ||
                     op_i == cag_pkg::CAG_OP_STS) ? data_word_i
                                                  : eff_ind;
  assign in_regs  = eff_addr < cag_pkg::IO_BASE;
  assign in_io    = !in_regs && eff_addr < cag_pkg::SRAM_BASE;
  assign in_sram  = !in_regs && !in_io;
  assign io_off   = eff_addr - cag_pkg::IO_BASE;

  // Pointer write-back happens in the accepting cycle
  assign ptr_wb = accept &&
                  (op_i == cag_pkg::CAG_OP_LD || op_i == cag_pkg::CAG_OP_ST) &&
                  (ptr_mode_i == cag_pkg::CAG_PM_PREDEC ||
                   ptr_mode_i == cag_pkg::CAG_PM_POSTINC);

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  always_comb begin
    unique case (alu_op_i)
      cag_pkg::CAG_ALU_ADD: alu_res = rd_a + rd_b;
      cag_pkg::CAG_ALU_SUB: alu_res = rd_a - rd_b;
      cag_pkg::CAG_ALU_AND: alu_res = rd_a & rd_b;
      cag_pkg::CAG_ALU_OR:  alu_res = rd_a | rd_b;
      cag_pkg::CAG_ALU_XOR: alu_res = rd_a ^ rd_b;
      cag_pkg::CAG_ALU_MOV: alu_res = rd_b;
      cag_pkg::CAG_ALU_INC: alu_res = rd_a + 8'h01;
      cag_pkg::CAG_ALU_DEC: alu_res = rd_a - 8'h01;
      cag_pkg::CAG_ALU_COM: alu_res = ~rd_a;
      default:              alu_res = rd_a;
    endcase
  end

  // ----------------------------------------------------------------
  // Register write port
  // ----------------------------------------------------------------
  assign pm_byte = pend_hi ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0];

  always_comb begin
    wr_en   = 1'b0;
    wr_addr = dest_reg_i;
    wr_data = alu_res;
    if (state == cag_pkg::CAG_ST_WAIT) begin
      wr_addr = pend_reg;
      if (io_req_o && !io_we_o) begin
        wr_en   = 1'b1;
        wr_data = io_rdata_i;
      end else if (sram_req_o && !sram_we_o) begin
        wr_en   = 1'b1;
        wr_data = sram_rdata_i;
      end else if (pmem_rd_o) begin
        wr_en   = 1'b1;
        wr_data = pm_byte;
      end
    end else if (accept) begin
      if (op_i == cag_pkg::CAG_OP_ALU1 || op_i == cag_pkg::CAG_OP_ALU2) begin
        wr_en = 1'b1;
      end else if (is_ld && in_regs) begin
        wr_en   = 1'b1;
        wr_data = rd_c;
      end else if (is_st && in_regs) begin
        wr_en   = 1'b1;
        wr_addr = eff_addr[4:0];
        wr_data = rd_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  assign pc_inc1 = pc_o + cag_pkg::PC_STEP1;
  assign rel_tgt = pc_inc1 + {{2{rel_off_i[11]}}, rel_off_i};
  assign is_jump = (op_i == cag_pkg::CAG_OP_PTR_JUMP) ||
                   (op_i == cag_pkg::CAG_OP_PTR_CALL) ||
                   (op_i == cag_pkg::CAG_OP_REL_JUMP) ||
                   (op_i == cag_pkg::CAG_OP_REL_CALL);

  always_comb begin
    unique case (op_i)
      cag_pkg::CAG_OP_PTR_JUMP,
      cag_pkg::CAG_OP_PTR_CALL: next_pc = ptr_c[13:0];
      cag_pkg::CAG_OP_REL_JUMP,
      cag_pkg::CAG_OP_REL_CALL: next_pc = rel_tgt;
      cag_pkg::CAG_OP_LDS,
      cag_pkg::CAG_OP_STS:      next_pc = pc_o + cag_pkg::PC_STEP2;
      default:                  next_pc = pc_inc1;
    endcase
  end

  // Undivided system clock drives everything
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= cag_pkg::PC_RESET;
    end else if (accept) begin
      pc_o <= next_pc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flush_o    <= 1'b0;
      call_o     <= 1'b0;
      ret_addr_o <= cag_pkg::PC_RESET;
    end else begin
      flush_o <= accept && is_jump;
      call_o  <= accept && (op_i == cag_pkg::CAG_OP_PTR_CALL ||
                            op_i == cag_pkg::CAG_OP_REL_CALL);
      if (accept) begin
        ret_addr_o <= pc_inc1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every outside access except a program memory store holds issue for one extra cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= cag_pkg::CAG_ST_EXEC;
    end else begin
      unique case (state)
        cag_pkg::CAG_ST_EXEC: begin
          if (accept && ((is_mem && !in_regs) ||
                         op_i == cag_pkg::CAG_OP_IO_IN ||
                         op_i == cag_pkg::CAG_OP_IO_OUT ||
                         op_i == cag_pkg::CAG_OP_PM_LOAD)) begin
            state <= cag_pkg::CAG_ST_WAIT;
          end
        end
        cag_pkg::CAG_ST_WAIT: state <= cag_pkg::CAG_ST_EXEC;
        default:              state <= cag_pkg::CAG_ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 5'h00;
      pend_hi  <= 1'b0;
    end else if (accept) begin
      pend_reg <= dest_reg_i;
      pend_hi  <= ptr_c[0];
    end
  end

  // ----------------------------------------------------------------
  // Data space requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_req_o   <= 1'b0;
      io_we_o    <= 1'b0;
      io_addr_o  <= 6'h00;
      io_wdata_o <= 8'h00;
    end else if (accept && (op_i == cag_pkg::CAG_OP_IO_IN ||
                            op_i == cag_pkg::CAG_OP_IO_OUT)) begin
      io_req_o   <= 1'b1;
      io_we_o    <= (op_i == cag_pkg::CAG_OP_IO_OUT);
      io_addr_o  <= io_addr_i;
      io_wdata_o <= rd_a;
    end else if (accept && is_mem && in_io) begin
      io_req_o   <= 1'b1;
      io_we_o    <= is_st;
      io_addr_o  <= io_off[5:0];
      io_wdata_o <= rd_a;
    end else begin
      io_req_o <= 1'b0;
      io_we_o  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sram_req_o   <= 1'b0;
      sram_we_o    <= 1'b0;
      sram_addr_o  <= 16'h0000;
      sram_wdata_o <= 8'h00;
    end else if (accept && is_mem && in_sram) begin
      sram_req_o   <= 1'b1;
      sram_we_o    <= is_st;
      sram_addr_o  <= eff_addr;
      sram_wdata_o <= rd_a;
    end else begin
      sram_req_o <= 1'b0;
      sram_we_o  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Program memory byte access
  // ----------------------------------------------------------------
  // Store ignores pointer_c bit 0; software must keep it clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pmem_rd_o    <= 1'b0;
      pmem_wr_o    <= 1'b0;
      pmem_addr_o  <= 14'h0000;
      pmem_wdata_o <= 16'h0000;
    end else begin
      pmem_rd_o <= accept && (op_i == cag_pkg::CAG_OP_PM_LOAD);
      pmem_wr_o <= accept && (op_i == cag_pkg::CAG_OP_PM_STORE);
      if (accept && (op_i == cag_pkg::CAG_OP_PM_LOAD ||
                     op_i == cag_pkg::CAG_OP_PM_STORE)) begin
        // Bit 15 would address past the 16K-word space
        pmem_addr_o  <= ptr_c[14:1];
        pmem_wdata_o <= pair0;
      end
    end
  end
endmodule

// ### cag_regfile.sv
package cag_pkg;
  localparam int          PC_W       = 14;
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 16;
  localparam int          REG_CNT    = 32;
  localparam int          REG_AW     = 5;
  localparam int          IO_AW      = 6;
  localparam int          DISP_W     = 6;
  localparam int          REL_W      = 12;
  localparam int          CLK_MHZ    = 100;
  localparam int          SRAM_CYC   = 2;
  localparam logic [15:0] IO_BASE    = 16'h0020;
  localparam logic [15:0] SRAM_BASE  = 16'h0060;
  localparam logic [4:0]  PTR_A_LO   = 5'h1A;
  localparam logic [4:0]  PTR_B_LO   = 5'h1C;
  localparam logic [4:0]  PTR_C_LO   = 5'h1E;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [13:0] PC_RESET   = 14'h0000;
  localparam logic [13:0] PC_STEP1   = 14'h0001;
  localparam logic [13:0] PC_STEP2   = 14'h0002;
  localparam logic [15:0] PTR_STEP   = 16'h0001;

  typedef enum logic [3:0] {
    CAG_OP_NOP, CAG_OP_ALU1, CAG_OP_ALU2, CAG_OP_IO_IN, CAG_OP_IO_OUT,
    CAG_OP_LDS, CAG_OP_STS, CAG_OP_LD, CAG_OP_ST, CAG_OP_PM_LOAD,
    CAG_OP_PM_STORE, CAG_OP_PTR_JUMP, CAG_OP_PTR_CALL, CAG_OP_REL_JUMP,
    CAG_OP_REL_CALL
  } cag_op_t;

  typedef enum logic [1:0] {
    CAG_PTR_A, CAG_PTR_B, CAG_PTR_C
  } cag_ptr_t;

  typedef enum logic [1:0] {
    CAG_PM_PLAIN, CAG_PM_PREDEC, CAG_PM_POSTINC, CAG_PM_DISP
  } cag_pmode_t;

  typedef enum logic [3:0] {
    CAG_ALU_ADD, CAG_ALU_SUB, CAG_ALU_AND, CAG_ALU_OR, CAG_ALU_XOR,
    CAG_ALU_MOV, CAG_ALU_INC, CAG_ALU_DEC, CAG_ALU_COM
  } cag_alu_t;

  typedef enum logic [1:0] {
    CAG_ST_EXEC = 2'b01,
    CAG_ST_WAIT = 2'b10
  } cag_state_t;
endpackage

module cag_regfile (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [4:0]        wr_addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              pair_wr_en_i,
  input  wire cag_pkg::cag_ptr_t pair_sel_i,
  input  wire logic [15:0]       pair_data_i,
  input  wire logic [4:0]        rd_a_addr_i,
  input  wire logic [4:0]        rd_b_addr_i,
  input  wire logic [4:0]        rd_c_addr_i,
  output logic      [7:0]        rd_a_data_o,
  output logic      [7:0]        rd_b_data_o,
  output logic      [7:0]        rd_c_data_o,
  output logic      [15:0]       ptr_a_o,
  output logic      [15:0]       ptr_b_o,
  output logic      [15:0]       ptr_c_o,
  output logic      [15:0]       pair0_o
);
  logic [7:0] regs [cag_pkg::REG_CNT];
  logic [4:0] pair_lo;
  logic [4:0] pair_hi;

  always_comb begin
    unique case (pair_sel_i)
      cag_pkg::CAG_PTR_A: pair_lo = cag_pkg::PTR_A_LO;
      cag_pkg::CAG_PTR_B: pair_lo = cag_pkg::PTR_B_LO;
      cag_pkg::CAG_PTR_C: pair_lo = cag_pkg::PTR_C_LO;
      default:            pair_lo = cag_pkg::PTR_C_LO;
    endcase
  end
  assign pair_hi = pair_lo | 5'h01;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Pointer update wins over a byte write to the same register
  for (genvar i = 0; i < cag_pkg::REG_CNT; i++) begin : g_reg
    localparam logic [4:0] IDX = 5'(i);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        regs[i] <= cag_pkg::REG_RESET;
      end else if (pair_wr_en_i && pair_lo == IDX) begin
        regs[i] <= pair_data_i[7:0];
      end else if (pair_wr_en_i && pair_hi == IDX) begin
        regs[i] <= pair_data_i[15:8];
      end else if (wr_en_i && wr_addr_i == IDX) begin
        regs[i] <= wr_data_i;
      end
    end
  end

  assign rd_a_data_o = regs[rd_a_addr_i];
  assign rd_b_data_o = regs[rd_b_addr_i];
  assign rd_c_data_o = regs[rd_c_addr_i];
  assign ptr_a_o     = {regs[cag_pkg::PTR_A_LO + 5'h01],
                        regs[cag_pkg::PTR_A_LO]};
  assign ptr_b_o     = {regs[cag_pkg::PTR_B_LO + 5'h01],
                        regs[cag_pkg::PTR_B_LO]};
  assign ptr_c_o     = {regs[cag_pkg::PTR_C_LO + 5'h01],
                        regs[cag_pkg::PTR_C_LO]};
  assign pair0_o     = {regs[1], regs[0]};
endmodule

// ### cag_addr_gen_asserts.sv
module cag_addr_gen_asserts (
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             instr_valid_i,
  input wire cag_pkg::cag_op_t op_i,
  input wire logic [15:0]      data_word_i,
  input wire logic [5:0]       io_addr_i,
  input wire logic [11:0]      rel_off_i,
  input wire logic             ready_o,
  input wire logic [13:0]      pc_o,
  input wire logic             flush_o,
  input wire logic             call_o,
  input wire logic [13:0]      ret_addr_o,
  input wire logic             io_req_o,
  input wire logic             io_we_o,
  input wire logic [5:0]       io_addr_o,
  input wire logic             sram_req_o,
  input wire logic             sram_we_o,
  input wire logic [15:0]      sram_addr_o,
  input wire logic             pmem_rd_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic        take;
  logic [13:0] rel_tgt;
  logic [13:0] nxt_pc;
  logic [15:0] io_off;
  assign take    = instr_valid_i && ready_o;
  assign rel_tgt = pc_o + cag_pkg::PC_STEP1 + {{2{rel_off_i[11]}}, rel_off_i};
  assign nxt_pc  = pc_o + cag_pkg::PC_STEP1;
  assign io_off  = data_word_i - cag_pkg::IO_BASE;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rel_target_a: assert property (
    take && (op_i == cag_pkg::CAG_OP_REL_JUMP || op_i == cag_pkg::CAG_OP_REL_CALL)
    |=> flush_o && pc_o == $past(rel_tgt))
    else $error("relative target wrong");
  call_link_a: assert property (
    take && (op_i == cag_pkg::CAG_OP_REL_CALL || op_i == cag_pkg::CAG_OP_PTR_CALL)
    |=> call_o && ret_addr_o == $past(nxt_pc)) else $error("call link wrong");
  ptr_jump_a: assert property (
    take && op_i == cag_pkg::CAG_OP_PTR_JUMP |=> flush_o && !call_o)
    else $error("pointer jump not taken");
  alu_single_a: assert property (
    take && op_i inside {cag_pkg::CAG_OP_ALU1, cag_pkg::CAG_OP_ALU2}
    |=> ready_o && pc_o == $past(nxt_pc))
    else $error("alu op not single cycle");
  sts_sram_a: assert property (
    take && op_i == cag_pkg::CAG_OP_STS && data_word_i >= cag_pkg::SRAM_BASE
    |=> sram_req_o && sram_we_o && sram_addr_o == $past(data_word_i))
    else $error("direct store to sram wrong");
  sts_io_a: assert property (
    take && op_i == cag_pkg::CAG_OP_STS && data_word_i >= cag_pkg::IO_BASE
    && data_word_i < cag_pkg::SRAM_BASE
    |=> io_req_o && io_we_o && io_addr_o == $past(io_off[5:0]))
    else $error("direct store to io wrong");
  io_out_a: assert property (
    take && op_i == cag_pkg::CAG_OP_IO_OUT
    |=> io_req_o && io_we_o && io_addr_o == $past(io_addr_i))
    else $error("io direct address wrong");
  sram_two_a: assert property (
    sram_req_o |-> !ready_o ##1 (ready_o && !sram_req_o))
    else $error("sram access not two cycles");
  pm_load_a: assert property (
    take && op_i == cag_pkg::CAG_OP_PM_LOAD
    |=> pmem_rd_o && !ready_o ##1 ready_o)
    else $error("program byte load timing wrong");
  flush_pulse_a: assert property (
    flush_o |=> !flush_o) else $error("flush longer than one cycle");

  cover property (take && op_i == cag_pkg::CAG_OP_REL_CALL);
  cover property (sram_req_o && !sram_we_o);
  cover property (take && op_i == cag_pkg::CAG_OP_PM_STORE);
endmodule

bind cag_addr_gen cag_addr_gen_asserts chk_u (.clk_i, .rst_n_i, .instr_valid_i,
  .op_i, .data_word_i, .io_addr_i, .rel_off_i, .ready_o, .pc_o, .flush_o,
  .call_o, .ret_addr_o, .io_req_o, .io_we_o, .io_addr_o, .sram_req_o,
  .sram_we_o, .sram_addr_o, .pmem_rd_o);

// ### cag_mem_model.sv
module cag_mem_model (
  input  wire logic        clk_i,
  input  wire logic        io_req_i,
  input  wire logic        io_we_i,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        sram_req_i,
  input  wire logic        sram_we_i,
  input  wire logic [15:0] sram_addr_i,
  input  wire logic [7:0]  sram_wdata_i,
  input  wire logic        pmem_rd_i,
  input  wire logic [13:0] pmem_addr_i,
  output logic      [7:0]  io_rdata_o,
  output logic      [7:0]  sram_rdata_o,
  output logic      [15:0] pmem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] io_mem [64];
  logic [7:0] ram [256];
  logic [7:0] junk = 8'h5A;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Plain always: the bench preloads io_mem too
  always @(posedge clk_i) begin
    junk <= junk + 8'h3B;
    if (io_req_i && io_we_i) io_mem[io_addr_i] <= io_wdata_i;
    if (sram_req_i && sram_we_i) ram[sram_addr_i[7:0]] <= sram_wdata_i;
  end
  // Idle buses show a moving pattern so stale data never matches
  assign io_rdata_o   = (io_req_i && !io_we_i) ? io_mem[io_addr_i]
                                               : junk;
  assign sram_rdata_o = (sram_req_i && !sram_we_i) ? ram[sram_addr_i[7:0]]
                                                   : ~junk;
  assign pmem_rdata_o = pmem_rd_i ? {~pmem_addr_i[7:0], pmem_addr_i[7:0]}
                                  : {junk, ~junk};
endmodule

// ### tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                instr_valid_i = 1'b0;
  cag_pkg::cag_op_t    op_i = cag_pkg::CAG_OP_NOP;
  cag_pkg::cag_alu_t   alu_op_i = cag_pkg::CAG_ALU_ADD;
  cag_pkg::cag_ptr_t   ptr_sel_i = cag_pkg::CAG_PTR_A;
  cag_pkg::cag_pmode_t ptr_mode_i = cag_pkg::CAG_PM_PLAIN;
  logic [4:0]          dest_reg_i = 5'h00, src_reg_i = 5'h00;
  logic [5:0]          io_addr_i = 6'h00, disp_i = 6'h00;
  logic [15:0]         data_word_i = 16'h0000;
  logic [11:0]         rel_off_i = 12'h000;
  logic [7:0]          io_rdata_i, sram_rdata_i, io_wdata_o, sram_wdata_o, v;
  logic [15:0]         pmem_rdata_i, sram_addr_o, pmem_wdata_o;
  logic                ready_o, flush_o, call_o, io_req_o, io_we_o;
  logic                sram_req_o, sram_we_o, pmem_rd_o, pmem_wr_o;
  logic [13:0]         pc_o, ret_addr_o, pmem_addr_o;
  logic [5:0]          io_addr_o;
  int                  bad_count = 0, cmp_count = 0, cyc = 0;

  cag_addr_gen uut (.clk_i, .rst_n_i, .instr_valid_i, .op_i, .alu_op_i,
    .dest_reg_i, .src_reg_i, .io_addr_i, .ptr_sel_i, .ptr_mode_i, .disp_i,
    .data_word_i, .rel_off_i, .io_rdata_i, .sram_rdata_i, .pmem_rdata_i,
    .ready_o, .pc_o, .flush_o, .call_o, .ret_addr_o, .io_req_o, .io_we_o,
    .io_addr_o, .io_wdata_o, .sram_req_o, .sram_we_o, .sram_addr_o,
    .sram_wdata_o, .pmem_rd_o, .pmem_wr_o, .pmem_addr_o, .pmem_wdata_o);
  cag_mem_model mem (.clk_i, .io_req_i(io_req_o), .io_we_i(io_we_o),
    .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o), .sram_req_i(sram_req_o),
    .sram_we_i(sram_we_o), .sram_addr_i(sram_addr_o),
    .sram_wdata_i(sram_wdata_o), .pmem_rd_i(pmem_rd_o),
    .pmem_addr_i(pmem_addr_o), .io_rdata_o(io_rdata_i),
    .sram_rdata_o(sram_rdata_i), .pmem_rdata_o(pmem_rdata_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Leaves valid high; returns at the falling edge after acceptance
  task automatic go(input cag_pkg::cag_op_t op);
    int n;
    n = 0;
    op_i = op;
    instr_valid_i = 1'b1;
    while (ready_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic idle;
    instr_valid_i = 1'b0;
    @(negedge clk_i);
  endtask
  // Idle first so a pending read does not see the new preload
  task automatic set_reg(input logic [4:0] r, input logic [7:0] d);
    idle();
    mem.io_mem[6'h3F] = d;
    dest_reg_i = r;
    io_addr_i = 6'h3F;
    go(cag_pkg::CAG_OP_IO_IN);
  endtask
  task automatic get_reg(input logic [4:0] r, output logic [7:0] d);
    dest_reg_i = r;
    io_addr_i = 6'h2A;
    go(cag_pkg::CAG_OP_IO_OUT);
    d = io_wdata_o;
  endtask
  task automatic set_ptr(input logic [4:0] lo, input logic [15:0] w);
    set_reg(lo, w[7:0]);
    set_reg(lo + 5'h01, w[15:8]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_alu;
    set_reg(5'd1, 8'h05);
    set_reg(5'd2, 8'h07);
    alu_op_i = cag_pkg::CAG_ALU_ADD;
    dest_reg_i = 5'd1;
    src_reg_i = 5'd2;
    go(cag_pkg::CAG_OP_ALU2);
    go(cag_pkg::CAG_OP_ALU2);
    get_reg(5'd1, v);
    chk(v, 16'h0013);
    set_reg(5'd3, 8'h0F);
    alu_op_i = cag_pkg::CAG_ALU_COM;
    dest_reg_i = 5'd3;
    go(cag_pkg::CAG_OP_ALU1);
    get_reg(5'd3, v);
    chk(v, 16'h00F0);
  endtask
  task automatic t_direct;
    dest_reg_i = 5'd1;
    data_word_i = 16'h0005;
    go(cag_pkg::CAG_OP_STS);
    get_reg(5'd5, v);
    chk(v, 16'h0013);
    dest_reg_i = 5'd1;
    data_word_i = 16'h0045;
    go(cag_pkg::CAG_OP_STS);
    chk(io_addr_o, 16'h0025);
    chk(io_req_o, 16'h0001);
    chk(io_we_o, 16'h0001);
    dest_reg_i = 5'd1;
    data_word_i = 16'h0123;
    go(cag_pkg::CAG_OP_STS);
    chk(sram_addr_o, 16'h0123);
    chk(sram_we_o, 16'h0001);
    chk(sram_wdata_o, 16'h0013);
    dest_reg_i = 5'd7;
    go(cag_pkg::CAG_OP_LDS);
    get_reg(5'd7, v);
    chk(v, 16'h0013);
  endtask
  task automatic t_ptr;
    cag_pkg::cag_pmode_t md [4];
    logic [15:0]         ea [4];
    md = '{cag_pkg::CAG_PM_POSTINC, cag_pkg::CAG_PM_PREDEC,
           cag_pkg::CAG_PM_PLAIN, cag_pkg::CAG_PM_DISP};
    ea = '{16'h0110, 16'h0110, 16'h0110, 16'h014F};
    set_ptr(cag_pkg::PTR_B_LO, 16'h0110);
    ptr_sel_i = cag_pkg::CAG_PTR_B;
    disp_i = 6'h3F;
    for (int i = 0; i < 4; i++) begin
      ptr_mode_i = md[i];
      dest_reg_i = 5'd8;
      go(cag_pkg::CAG_OP_LD);
      chk(sram_addr_o, ea[i]);
    end
    get_reg(5'd28, v);
    chk(v, 16'h0010);
    set_ptr(cag_pkg::PTR_A_LO, 16'h0080);
    ptr_sel_i = cag_pkg::CAG_PTR_A;
    ptr_mode_i = cag_pkg::CAG_PM_POSTINC;
    dest_reg_i = 5'd1;
    go(cag_pkg::CAG_OP_ST);
    chk(sram_addr_o, 16'h0080);
    get_reg(5'd26, v);
    chk(v, 16'h0081);
    set_ptr(cag_pkg::PTR_C_LO, 16'h0200);
    ptr_sel_i = cag_pkg::CAG_PTR_C;
    ptr_mode_i = cag_pkg::CAG_PM_PREDEC;
    dest_reg_i = 5'd1;
    go(cag_pkg::CAG_OP_ST);
    chk(sram_addr_o, 16'h01FF);
    get_reg(5'd31, v);
    chk(v, 16'h0001);
    ptr_mode_i = cag_pkg::CAG_PM_DISP;
    dest_reg_i = 5'd8;
    go(cag_pkg::CAG_OP_LD);
    chk(sram_addr_o, 16'h023E);
  endtask
  task automatic t_pmem;
    set_ptr(cag_pkg::PTR_C_LO, 16'h0035);
    dest_reg_i = 5'd6;
    go(cag_pkg::CAG_OP_PM_LOAD);
    chk(pmem_addr_o, 16'h001A);
    chk(pmem_rd_o, 16'h0001);
    get_reg(5'd6, v);
    chk(v, 16'h00E5);
    set_reg(5'd30, 8'h34);
    dest_reg_i = 5'd6;
    go(cag_pkg::CAG_OP_PM_LOAD);
    get_reg(5'd6, v);
    chk(v, 16'h001A);
    set_reg(5'd0, 8'hAB);
    set_reg(5'd1, 8'hCD);
    go(cag_pkg::CAG_OP_PM_STORE);
    chk(pmem_wr_o, 16'h0001);
    chk(pmem_wdata_o, 16'hCDAB);
  endtask
  task automatic t_jump;
    set_ptr(cag_pkg::PTR_C_LO, 16'h1234);
    go(cag_pkg::CAG_OP_PTR_JUMP);
    chk(pc_o, 16'h1234);
    chk(flush_o, 16'h0001);
    idle();
    rel_off_i = 12'h800;
    go(cag_pkg::CAG_OP_REL_JUMP);
    chk(pc_o, 16'h0A35);
    idle();
    rel_off_i = 12'h7FF;
    go(cag_pkg::CAG_OP_REL_CALL);
    chk(pc_o, 16'h1235);
    chk(ret_addr_o, 16'h0A36);
    set_ptr(cag_pkg::PTR_C_LO, 16'h3FFE);
    go(cag_pkg::CAG_OP_PTR_CALL);
    chk(call_o, 16'h0001);
    idle();
    rel_off_i = 12'h005;
    go(cag_pkg::CAG_OP_REL_JUMP);
    chk(pc_o, 16'h0004);
  endtask

  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(pc_o, 16'h0000);
    chk(ready_o, 16'h0001);
    t_alu();
    t_direct();
    t_ptr();
    t_pmem();
    t_jump();
    idle();
    test_done();
  end
endmodule
